// >>> design/sprd_map.svh
`ifndef SPRD_MAP_SVH
`define SPRD_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPRD_CFG0_OFF 8'h00
`define SPRD_CFG1_OFF 8'h04
`define SPRD_MBOX_OFF 8'h08
`define SPRD_STAT_OFF 8'h0c
`define SPRD_DRV_OFF 8'h10

// ----------------------------------------
// Port configuration fields
// ----------------------------------------
`define SPRD_CFG_W 17
`define SPRD_CFG_DROP_LSB 0
`define SPRD_CFG_DROP_MSB 7
`define SPRD_CFG_MODE_LSB 8
`define SPRD_CFG_MODE_MSB 10
`define SPRD_CFG_DRV_LSB 12
`define SPRD_CFG_DRV_MSB 13
`define SPRD_CFG_ONETH_BIT 16
`define SPRD_CFG_WMASK 17'h137ff

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPRD_CFG0_RST 17'h00001
`define SPRD_CFG1_RST 17'h00002
`define SPRD_MBOX_RST 32'h00000000

// ----------------------------------------
// Drops, message kinds and opcodes
// ----------------------------------------
`define SPRD_NO_ROUTE 8'hff
`define SPRD_NULL_DROP 8'hcc
`define SPRD_DROP_MOD 8'h64
`define SPRD_DROP_MOD2 8'hc8
`define SPRD_KIND_READ 8'h01
`define SPRD_KIND_WRITE 8'h02
`define SPRD_KIND_PRINT 8'h03
`define SPRD_KIND_RANDOM 8'h04
`define SPRD_RANDOM_OP 8'h64

`endif

// >>> design/sprd_pair_buf.sv
`timescale 1ns/1ps

module sprd_pair_buf #(
  parameter int W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  // ----------------------------------------
  // Two entries, head always in outData
  // ----------------------------------------
  logic [1:0] cntQ;
  logic [1:0] cntD;
  logic [W-1:0] tailQ;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign cntD = cntQ + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cntQ <= 2'h0;
      outValid <= 1'b0;
      inReady <= 1'b0;
      outData <= '0;
      tailQ <= '0;
    end else begin
      cntQ <= cntD;
      outValid <= cntD != 2'h0;
      // Ready is registered, so a full pair blocks the source next cycle
      inReady <= cntD != 2'h2;
      if (pop) begin
        outData <= (cntQ == 2'h2) ? tailQ : inData;
      end else if (push && cntQ == 2'h0) begin
        outData <= inData;
      end
      if (push && (cntQ - {1'b0, pop}) == 2'h1) begin
        tailQ <= inData;
      end
    end
  end

endmodule // sprd_pair_buf

// >>> design/sprd_pkg.sv
`include "sprd_map.svh"

package sprd_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    NATIVE_NET_MODE,
    NETWORK_BRIDGE_MODE,
    PRINTER_MODE,
    GATEWAY_MODE,
    POLL_HOST_MODE
  } sprd_mode_e;

  typedef enum logic [1:0] {
    POINT_TO_POINT_DRIVE,
    FOUR_LINE_SLAVE_DRIVE,
    HALF_DUPLEX_DRIVE,
    TWO_WIRE_DRIVE
  } sprd_drv_e;

  typedef enum logic [1:0] {POS_ROUTE, POS_KIND, POS_BODY} sprd_pos_e;

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  // Unused mode codes fall back to native so a bad write cannot hang ports
  function automatic sprd_mode_e modeOf(input logic [2:0] f);
    case (f)
      3'h1: return NETWORK_BRIDGE_MODE;
      3'h2: return PRINTER_MODE;
      3'h3: return GATEWAY_MODE;
      3'h4: return POLL_HOST_MODE;
      default: return NATIVE_NET_MODE;
    endcase
  endfunction

  function automatic sprd_drv_e drvOf(input logic [1:0] f);
    case (f)
      2'h1: return FOUR_LINE_SLAVE_DRIVE;
      2'h2: return HALF_DUPLEX_DRIVE;
      2'h3: return TWO_WIRE_DRIVE;
      default: return POINT_TO_POINT_DRIVE;
    endcase
  endfunction

  function automatic logic [7:0] ethDropOf(input logic [7:0] d);
    if (d >= `SPRD_DROP_MOD2) begin
      return d - `SPRD_DROP_MOD2;
    end else if (d >= `SPRD_DROP_MOD) begin
      return d - `SPRD_DROP_MOD;
    end
    return d;
  endfunction

endpackage

// >>> design/sprd_route_ctrl.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "sprd_map.svh"

// Function
// [RULE1] Native packet for sibling native/bridge port is resent there
// [RULE2] No route, null drop 204 or foreign drop: handled internally
// [RULE3] Internal read/write messages reach mailbox or configuration registers; a read only latches its index byte into the status register
// [RULE4] Bridge link ends both run bridge mode with identical drop
// [RULE5] Bridge port on Ethernet also answers drop number modulo one hundred
// [RULE6] No other Ethernet node may reuse that presented drop
// [RULE7] Printer port takes print requests via native or bridge siblings
// [RULE8] Printer port sends print request contents as raw ASCII
// [RULE9] Print route lists origin port drop, bridge drops, printer drop
// [RULE10] Point-to-point drive: transmitter always on, receiver always on
// [RULE11] Four-line drive: transmitter follows CTS, otherwise high impedance
// [RULE12] Half duplex: transmitter always on, receiver off while sending
// [RULE13] Two-wire drive: transmitter follows CTS, receiver off while sending
// [RULE14] Gateway turns random reads into opcode 100 and back
// [RULE15] Host port splits random read into one ordinary read per element
// [RULE16] Two-bit per-port field selects the driver mode
module sprd_route_ctrl
  import sprd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Received packet bytes
  input wire logic rxPktValid,
  output logic rxPktReady,
  input wire logic rxPktPort,
  input wire logic rxPktSop,
  input wire logic rxPktEop,
  input wire logic [7:0] rxPktData,
  // Packet bytes to serial transmitters
  output logic txPktValid,
  input wire logic txPktReady,
  output logic txPktPort,
  output logic txPktSop,
  output logic txPktEop,
  output logic [7:0] txPktData,
  // Line drivers
  input wire logic [1:0] ctsPin,
  input wire logic [1:0] txBusy,
  output logic [1:0] txDrvEn,
  output logic [1:0] rxEn,
  // Ethernet presence
  output logic [1:0] ethPresent,
  output logic [1:0][7:0] ethDrop
);

  // ----------------------------------------
  // Buffers on both sides of the router
  // ----------------------------------------
  localparam int BW = 11;
  logic [BW-1:0] ibData;
  logic [BW-1:0] obData;
  logic [BW-1:0] txWord;
  logic ibValid;
  logic ibTake;
  logic obValid;
  logic obReady;

  sprd_pair_buf #(.W(BW)) inBuf (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(rxPktValid),
    .inReady(rxPktReady),
    .inData({rxPktPort, rxPktSop, rxPktEop, rxPktData}),
    .outValid(ibValid),
    .outReady(ibTake),
    .outData(ibData)
  );

  sprd_pair_buf #(.W(BW)) outBuf (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(obValid),
    .inReady(obReady),
    .inData(obData),
    .outValid(txPktValid),
    .outReady(txPktReady),
    .outData(txWord)
  );

  assign txPktPort = txWord[10];
  assign txPktSop = txWord[9];
  assign txPktEop = txWord[8];
  assign txPktData = txWord[7:0];

  // ----------------------------------------
  // Port configuration decode
  // ----------------------------------------
  logic [`SPRD_CFG_W-1:0] cfgQ [2];
  logic [7:0] dropP [2];
  logic [7:0] presDrop [2];
  sprd_mode_e modeP [2];
  sprd_drv_e drvP [2];
  logic [1:0] presOn;
  logic [1:0] hit;
  logic [1:0] txD;
  logic [1:0] rxD;
  logic [1:0] ctsS1Q;
  logic [1:0] ctsS2Q;
  logic srcP;
  logic sopIn;
  logic eopIn;
  logic [7:0] byteIn;

  assign srcP = ibData[10];
  assign sopIn = ibData[9];
  assign eopIn = ibData[8];
  assign byteIn = ibData[7:0];

  for (genvar p = 0; p < 2; p++) begin : gPort
    assign dropP[p] = cfgQ[p][`SPRD_CFG_DROP_MSB:`SPRD_CFG_DROP_LSB];
    assign modeP[p] = modeOf(cfgQ[p][`SPRD_CFG_MODE_MSB:`SPRD_CFG_MODE_LSB]);
    assign drvP[p] =
      drvOf(cfgQ[p][`SPRD_CFG_DRV_MSB:`SPRD_CFG_DRV_LSB]); // [RULE16]
    assign presDrop[p] = ethDropOf(dropP[p]); // [RULE5]
    assign presOn[p] = modeP[p] == NETWORK_BRIDGE_MODE &&
                       cfgQ[p][`SPRD_CFG_ONETH_BIT]; // [RULE5]
    // A bridge port is reached by the drop it shares with its peer
    assign hit[p] = byteIn == dropP[p] ||
                    (presOn[p] && byteIn == presDrop[p]); // [RULE4]
    assign txD[p] = drvP[p] == POINT_TO_POINT_DRIVE || // [RULE10]
                    drvP[p] == HALF_DUPLEX_DRIVE || // [RULE12]
                    ctsS2Q[p]; // [RULE11] [RULE13]
    assign rxD[p] = drvP[p] == POINT_TO_POINT_DRIVE || // [RULE10]
                    drvP[p] == FOUR_LINE_SLAVE_DRIVE ||
                    !txBusy[p]; // [RULE12] [RULE13]
  end

  // ----------------------------------------
  // Routing decision
  // ----------------------------------------
  sprd_pos_e posQ;
  sprd_pos_e posNow;
  logic fwdQ;
  logic dstQ;
  logic [7:0] routeQ;
  logic [7:0] kindQ;
  logic [1:0] bodyCntQ;
  logic [1:0] subQ;
  logic [7:0] idxQ;
  logic dstPort;
  logic srcOk;
  logic fwdNow;
  logic fwdCur;
  logic dPortCur;
  sprd_mode_e srcMode;
  sprd_mode_e dModeCur;
  logic isHost;
  logic isPrn;
  logic split;
  logic [1:0] nOut;
  logic lastSub;
  logic [7:0] kindOut;
  logic [7:0] finalByte;
  logic [7:0] obByte;
  logic obSop;
  logic obEop;

  // A start flag always resynchronises to the route byte
  assign posNow = sopIn ? POS_ROUTE : posQ;
  assign dstPort = ~srcP;
  assign srcMode = modeP[srcP];
  assign srcOk = srcMode == NATIVE_NET_MODE ||
                 srcMode == NETWORK_BRIDGE_MODE ||
                 srcMode == GATEWAY_MODE; // [RULE1] [RULE7]
  // Own-port and foreign drops fall through to internal handling
  assign fwdNow = byteIn != `SPRD_NO_ROUTE &&
                  byteIn != `SPRD_NULL_DROP &&
                  hit[dstPort] && srcOk; // [RULE1] [RULE2]
  assign fwdCur = (posNow == POS_ROUTE) ? fwdNow : fwdQ;
  assign dPortCur = (posNow == POS_ROUTE) ? dstPort : dstQ;
  assign dModeCur = modeP[dPortCur];
  assign isHost = dModeCur == POLL_HOST_MODE;
  assign isPrn = dModeCur == PRINTER_MODE;
  assign split = isHost && posNow == POS_BODY &&
                 kindQ == `SPRD_KIND_RANDOM; // [RULE15]

  // Output bytes produced by the current input byte
  assign nOut = !fwdCur ? 2'h0 :
                (posNow == POS_ROUTE) ? ((isHost || isPrn) ? 2'h0 : 2'h1) :
                (posNow == POS_KIND) ? (isPrn ? 2'h0 :
                  !isHost ? 2'h1 :
                  (byteIn == `SPRD_KIND_RANDOM) ? 2'h0 : 2'h2) :
                split ? 2'h3 : // [RULE15]
                !isPrn ? 2'h1 :
                (kindQ == `SPRD_KIND_PRINT) ? 2'h1 : 2'h0; // [RULE7]

  assign kindOut = (dModeCur == GATEWAY_MODE &&
                    byteIn == `SPRD_KIND_RANDOM) ? `SPRD_RANDOM_OP :
                   (srcMode == GATEWAY_MODE &&
                    byteIn == `SPRD_RANDOM_OP) ? `SPRD_KIND_RANDOM :
                   byteIn; // [RULE14]
  assign lastSub = subQ == (nOut - 2'h1);
  assign finalByte = (posNow == POS_KIND) ? kindOut : byteIn;
  // Host requests are rebuilt around each element
  assign obByte = lastSub ? finalByte :
                  (subQ == 2'h0) ? routeQ : `SPRD_KIND_READ; // [RULE15]
  assign obSop = subQ == 2'h0 &&
                 (posNow == POS_ROUTE ||
                  (isHost && (posNow == POS_KIND || split)) ||
                  (isPrn && bodyCntQ == 2'h0)); // [RULE8]
  assign obEop = lastSub && (split || eopIn);
  assign obData = {dPortCur, obSop, obEop, obByte};
  assign obValid = ibValid && nOut != 2'h0; // [RULE1] [RULE8]
  assign ibTake = ibValid && (nOut == 2'h0 || (obReady && lastSub));

  // ----------------------------------------
  // Internal message handling
  // ----------------------------------------
  logic inBody;
  logic msgWr;
  logic msgRd;
  logic cntRoute;

  assign inBody = ibTake && !fwdCur && posNow == POS_BODY;
  assign msgWr = inBody && bodyCntQ == 2'h1 &&
                 kindQ == `SPRD_KIND_WRITE; // [RULE3]
  assign msgRd = inBody && bodyCntQ == 2'h0 &&
                 kindQ == `SPRD_KIND_READ; // [RULE3]
  assign cntRoute = ibTake && posNow == POS_ROUTE;

  // ----------------------------------------
  // Packet walker
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      posQ <= POS_ROUTE;
      fwdQ <= 1'b0;
      dstQ <= 1'b0;
      routeQ <= 8'h00;
      kindQ <= 8'h00;
      bodyCntQ <= 2'h0;
      subQ <= 2'h0;
      idxQ <= 8'h00;
    end else begin
      if (obValid && obReady) begin
        subQ <= lastSub ? 2'h0 : subQ + 2'h1;
      end
      if (ibTake) begin
        posQ <= eopIn ? POS_ROUTE :
                (posNow == POS_ROUTE) ? POS_KIND : POS_BODY;
        bodyCntQ <= (posNow != POS_BODY) ? 2'h0 :
                    (bodyCntQ == 2'h2) ? 2'h2 : bodyCntQ + 2'h1;
        if (posNow == POS_ROUTE) begin
          fwdQ <= fwdNow;
          dstQ <= dstPort;
          routeQ <= byteIn;
        end
        if (posNow == POS_KIND) begin
          kindQ <= byteIn;
        end
        if (posNow == POS_BODY && bodyCntQ == 2'h0) begin
          idxQ <= byteIn;
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] mboxQ;
  logic [7:0] fwdCntQ;
  logic [7:0] intCntQ;
  logic [7:0] rdIdxQ;
  logic [31:0] rdMux;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgQ[0] <= `SPRD_CFG0_RST;
      cfgQ[1] <= `SPRD_CFG1_RST;
      mboxQ <= `SPRD_MBOX_RST;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (msgWr && idxQ[7] && idxQ[0] == p[0]) begin
          cfgQ[p][`SPRD_CFG_DROP_MSB:`SPRD_CFG_DROP_LSB] <= byteIn; // [RULE3]
        end else if (regWr && regAddr ==
                     (p[0] ? `SPRD_CFG1_OFF : `SPRD_CFG0_OFF)) begin
          cfgQ[p] <= regWdata[`SPRD_CFG_W-1:0] & `SPRD_CFG_WMASK;
        end
      end
      // A message write wins over a software write in the same cycle
      if (msgWr && !idxQ[7]) begin
        mboxQ[{idxQ[1:0], 3'h0} +: 8] <= byteIn; // [RULE3]
      end else if (regWr && regAddr == `SPRD_MBOX_OFF) begin
        mboxQ <= regWdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fwdCntQ <= 8'h00;
      intCntQ <= 8'h00;
      rdIdxQ <= 8'h00;
    end else begin
      if (cntRoute && fwdNow) begin
        fwdCntQ <= fwdCntQ + 8'h01;
      end
      if (cntRoute && !fwdNow) begin
        intCntQ <= intCntQ + 8'h01; // [RULE2]
      end
      if (msgRd) begin
        rdIdxQ <= byteIn;
      end
    end
  end

  assign rdMux =
    (regAddr == `SPRD_CFG0_OFF) ? {15'h0000, cfgQ[0]} :
    (regAddr == `SPRD_CFG1_OFF) ? {15'h0000, cfgQ[1]} :
    (regAddr == `SPRD_MBOX_OFF) ? mboxQ :
    (regAddr == `SPRD_STAT_OFF) ?
      {7'h00, posQ != POS_ROUTE, rdIdxQ, intCntQ, fwdCntQ} :
    (regAddr == `SPRD_DRV_OFF) ? {26'h0, ctsS2Q, rxEn, txDrvEn} :
    32'h00000000;

  // ----------------------------------------
  // Read data, drivers and presence outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 32'h00000000;
      ctsS1Q <= 2'h0;
      ctsS2Q <= 2'h0;
      txDrvEn <= 2'h0;
      rxEn <= 2'h0;
      ethPresent <= 2'h0;
      ethDrop <= '0;
    end else begin
      regRdata <= regRd ? rdMux : 32'h00000000;
      ctsS1Q <= ctsPin;
      ctsS2Q <= ctsS1Q;
      // One cycle late against CTS; the sync costs two more
      txDrvEn <= txD; // [RULE11] [RULE13]
      rxEn <= rxD; // [RULE12] [RULE13]
      ethPresent <= presOn; // [RULE5]
      ethDrop[0] <= presDrop[0];
      ethDrop[1] <= presDrop[1];
    end
  end

endmodule // sprd_route_ctrl

// >>> sim/sprd_route_ctrl_sva.sv
`timescale 1ns/1ps
`include "sprd_map.svh"

module sprd_route_ctrl_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  // Packet streams
  input wire logic rxPktValid,
  input wire logic rxPktReady,
  input wire logic rxPktSop,
  input wire logic [7:0] rxPktData,
  input wire logic txPktValid,
  input wire logic txPktReady,
  input wire logic txPktPort,
  input wire logic [7:0] txPktData,
  // Drivers and Ethernet
  input wire logic [1:0] ctsPin,
  input wire logic [1:0] txBusy,
  input wire logic [1:0] txDrvEn,
  input wire logic [1:0] rxEn,
  input wire logic [1:0] ethPresent,
  input wire logic [1:0][7:0] ethDrop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_rd_idle;
    !$past(regRd) |-> regRdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");

  property p_drv_stat;
    $past(regRd) && $past(regAddr) == `SPRD_DRV_OFF
      |-> regRdata[3:0] == {$past(rxEn), $past(txDrvEn)};
  endproperty
  a_drv_stat: assert property (p_drv_stat)
    else $error("driver status read wrong");

  // Stall must not lose or alter a byte
  property p_tx_hold;
    txPktValid && !txPktReady
      |=> txPktValid && $stable(txPktData) && $stable(txPktPort);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("output byte changed under stall");

  property p_drv_cts;
    (~txDrvEn & $past(ctsPin, 3)) == 2'b00;
  endproperty
  a_drv_cts: assert property (p_drv_cts)
    else $error("driver off while clear to send");

  // Enables still show reset zeros at the first edge after release
  property p_rx_busy;
    $past(rst_b) |-> (~rxEn & ~$past(txBusy)) == 2'b00;
  endproperty
  a_rx_busy: assert property (p_rx_busy)
    else $error("receiver off while idle");

  property p_eth_mod;
    ethDrop[0] < 8'h64 && ethDrop[1] < 8'h64;
  endproperty
  a_eth_mod: assert property (p_eth_mod)
    else $error("presented drop not below one hundred");

  sequence s_head(logic [7:0] d);
    rxPktValid && rxPktReady && rxPktSop && rxPktData == d;
  endsequence

  property p_null;
    s_head(`SPRD_NULL_DROP) |=> !txPktValid [*4];
  endproperty
  a_null: assert property (p_null)
    else $error("null drop packet forwarded");

  property p_noroute;
    s_head(`SPRD_NO_ROUTE) |=> !txPktValid [*4];
  endproperty
  a_noroute: assert property (p_noroute)
    else $error("unrouted packet forwarded");

  c_fwd: cover property (txPktValid && txPktReady);
  c_rd: cover property (regRd ##1 regRdata != 32'h0);
  c_eth: cover property (ethPresent[0]);
endmodule // sprd_route_ctrl_sva

bind sprd_route_ctrl sprd_route_ctrl_sva sprd_route_ctrl_sva_inst (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regRd(regRd),
  .regRdata(regRdata), .rxPktValid(rxPktValid), .rxPktReady(rxPktReady),
  .rxPktSop(rxPktSop), .rxPktData(rxPktData), .txPktValid(txPktValid),
  .txPktReady(txPktReady), .txPktPort(txPktPort), .txPktData(txPktData),
  .ctsPin(ctsPin), .txBusy(txBusy), .txDrvEn(txDrvEn), .rxEn(rxEn),
  .ethPresent(ethPresent), .ethDrop(ethDrop));

// >>> sim/sprd_tx_sink.sv
`timescale 1ns/1ps

module sprd_tx_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Byte stream from the block
  input wire logic txPktValid,
  output logic txPktReady,
  // Full stall request
  input wire logic hold
);
  integer seed = 32'h827d7148;

  // Slow or prompt at random, like a real serial transmitter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txPktReady <= 1'b0;
    end else begin
      // Idle sink stays ready; a waiting byte sees random stalls
      txPktReady <= !hold &&
                    (!txPktValid || ($random(seed) & 3) != 0);
    end
  end
endmodule // sprd_tx_sink

// >>> sim/test_serial_port_route_driver_ctrl.sv
`timescale 1ns/1ps

module test_serial_port_route_driver_ctrl;
  // ------
  // Signals
  // ------
  logic clk = 1'b0;
  logic rst_b;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic rxPktValid = 1'b0;
  logic rxPktReady;
  logic rxPktPort = 1'b0;
  logic dstP = 1'b1;
  logic rxPktSop = 1'b0;
  logic rxPktEop = 1'b0;
  logic [7:0] rxPktData = 8'h00;
  logic txPktValid, txPktReady, txPktPort, txPktSop, txPktEop;
  logic [7:0] txPktData;
  logic [1:0] ctsPin = 2'h0;
  logic [1:0] txBusy = 2'h0;
  logic [1:0] txDrvEn, rxEn, ethPresent;
  logic [1:0][7:0] ethDrop;
  logic hold = 1'b0;
  logic rdLast = 1'b0;
  logic d0, x0;
  logic [31:0] rdQ[$];
  logic [10:0] txQ[$];
  logic [7:0] pl[$];
  logic [7:0] ex[$];
  integer seed = 32'h827d7148;
  logic [31:0] r;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  sprd_route_ctrl sprd_route_ctrl_inst (.clk(clk), .rst_b(rst_b),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .rxPktValid(rxPktValid), .rxPktReady(rxPktReady),
    .rxPktPort(rxPktPort), .rxPktSop(rxPktSop), .rxPktEop(rxPktEop),
    .rxPktData(rxPktData), .txPktValid(txPktValid),
    .txPktReady(txPktReady), .txPktPort(txPktPort), .txPktSop(txPktSop),
    .txPktEop(txPktEop), .txPktData(txPktData), .ctsPin(ctsPin),
    .txBusy(txBusy), .txDrvEn(txDrvEn), .rxEn(rxEn),
    .ethPresent(ethPresent), .ethDrop(ethDrop));

  sprd_tx_sink sprd_tx_sink_inst (.clk(clk), .rst_b(rst_b),
    .txPktValid(txPktValid), .txPktReady(txPktReady), .hold(hold));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ------
  // Tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    rdQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask

  task automatic rnd(input int n);
    repeat (n) begin
      r = $random(seed);
      pl.push_back(r[7:0]);
    end
  endtask

  task automatic want();
    foreach (ex[i]) txQ.push_back({dstP, i == 0, i == ex.size() - 1, ex[i]});
  endtask

  task automatic send();
    foreach (pl[i]) begin
      @(posedge clk);
      rxPktValid <= 1'b1;
      rxPktSop <= i == 0;
      rxPktEop <= i == pl.size() - 1;
      rxPktData <= pl[i];
      @(negedge clk);
      while (rxPktReady !== 1'b1) @(negedge clk);
    end
    @(posedge clk);
    rxPktValid <= 1'b0;
  endtask

  // Bounded wait, then idle so the next packet starts clean
  task automatic go();
    int n;
    n = 0;
    want();
    send();
    while (txQ.size() != 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
  endtask

  // ------
  // Result watcher
  // ------
  always @(posedge clk) begin
    rdLast <= regRd;
    if (rdLast) begin
      if (rdQ.size() == 0) chk(1, 0);
      else chk(regRdata, rdQ.pop_front());
    end
    if (txPktValid && txPktReady) begin
      if (txQ.size() == 0) chk(1, 0);
      else chk({txPktPort, txPktSop, txPktEop, txPktData},
               txQ.pop_front());
    end
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  // ------
  // Scenarios
  // ------
  initial begin
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h2);
    rd(8'h20, 32'h0);
    rd(8'h10, 32'h0f);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      wr(8'h04, 32'h2 | (m << 8));
      pl = {8'h02, 8'h02};
      rnd(3);
      ex = pl;
      go();
    end
    @(posedge clk);
    hold <= 1'b1;
    pl = {8'h02, 8'h02};
    rnd(12);
    ex = pl;
    want();
    ex.delete();
    fork
      send();
    join_none
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(rxPktReady, 0);
    @(posedge clk);
    hold <= 1'b0;
    wait fork;
    // Only drain what is buffered; nothing new is sent
    pl.delete();
    go();
    $display("test forward done");
    wr(8'h04, 32'h302);
    pl = {8'h02, 8'h04};
    rnd(1);
    ex = {8'h02, 8'h64, pl[2]};
    go();
    rxPktPort <= 1'b1;
    dstP = 1'b0;
    pl = {8'h01, 8'h64};
    rnd(1);
    ex = {8'h01, 8'h04, pl[2]};
    go();
    rxPktPort <= 1'b0;
    dstP = 1'b1;
    wr(8'h04, 32'h402);
    pl = {8'h02, 8'h04};
    rnd(2);
    ex = {8'h02, 8'h01, pl[2]};
    want();
    ex = {8'h02, 8'h01, pl[3]};
    go();
    pl = {8'h02, 8'h01, 8'h55};
    ex = pl;
    go();
    wr(8'h04, 32'h202);
    pl = {8'h02, 8'h03, 8'h41, 8'h42, 8'h43};
    ex = {8'h41, 8'h42, 8'h43};
    go();
    pl = {8'h02, 8'h01, 8'h55};
    ex.delete();
    go();
    $display("test translate done");
    pl = {8'hff, 8'h02, 8'h00, 8'h5a};
    go();
    pl = {8'hcc, 8'h02, 8'h01, 8'ha5};
    go();
    pl = {8'h30, 8'h02, 8'h81, 8'h07};
    go();
    pl = {8'hff, 8'h01, 8'h3c};
    go();
    rd(8'h0c, 32'h003c0409);
    rd(8'h08, 32'h0000a55a);
    rd(8'h04, 32'h207);
    $display("test internal done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'h1 | (m << 12));
      repeat (3) begin
        r = $random(seed);
        @(posedge clk);
        ctsPin <= r[1:0];
        txBusy <= r[3:2];
        d0 = (m == 1 || m == 3) ? r[0] : 1'b1;
        x0 = (m < 2) ? 1'b1 : ~r[2];
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(txDrvEn[0], d0);
        chk(rxEn[0], x0);
      end
      rd(8'h10, {26'h0, r[1:0], 1'b1, x0, 1'b1, d0});
    end
    $display("test drivers done");
    // Port 0 keeps a drop other than the presented one
    wr(8'h00, 32'h10170);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({ethPresent[0], ethDrop[0]}, 9'h10c);
    $display("test ethernet done");
    repeat (4) @(posedge clk);
    chk(txQ.size(), 0);
    results();
  end
endmodule // test_serial_port_route_driver_ctrl
